// *** hdl/pwr_state_pkg.sv ***
// constants and types shared by the power-state controller
package pwr_state_pkg;
   localparam int unsigned CLK_HZ          = 25_000_000;
   localparam int unsigned LONG_PRESS_S    = 4;
   localparam int unsigned LONG_PRESS_CYC  = LONG_PRESS_S * CLK_HZ;
   localparam int unsigned DEBOUNCE_US     = 10_000;
   localparam int unsigned DEBOUNCE_CYC    = (DEBOUNCE_US * (CLK_HZ / 1_000_000));
   localparam int unsigned PRESS_W         = 27;
   localparam int unsigned DEB_W           = 18;
   localparam logic        SW_RESET_VAL    = 1'b0;
   localparam logic [1:0]  SLEEP_RESET_VAL = 2'h0;

   // which sleeping state is entered by a short press from working
   localparam logic [1:0] SLP_S3 = 2'h0;
   localparam logic [1:0] SLP_S4 = 2'h1;

   typedef enum logic [3:0] {
      ST_OFF   = 4'b0001,
      ST_WORK  = 4'b0010,
      ST_SLEEP = 4'b0100,
      ST_MECH  = 4'b1000
   } pstate_e;
endpackage

// *** hdl/switch_debounce.sv ***
// synchroniser and debouncer for the front-panel power switch
`timescale 1ns/1ns
module switch_debounce
   import pwr_state_pkg::*;
#(
   parameter int unsigned STABLE_CYC = DEBOUNCE_CYC
) (
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic raw,
   output logic      clean
);
   logic              sync1;
   logic              sync2;
   logic [DEB_W-1:0]  cnt;
   logic [DEB_W-1:0]  next_cnt;
   logic              next_clean;

   always_comb begin
      next_cnt   = cnt;
      next_clean = clean;
      if (sync2 == clean) begin
         next_cnt = '0;
      end else if (cnt >= DEB_W'(STABLE_CYC - 1)) begin
         next_clean = sync2;
         next_cnt   = '0;
      end else begin
         next_cnt = cnt + DEB_W'(1);
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1 <= SW_RESET_VAL;
         sync2 <= SW_RESET_VAL;
         cnt   <= '0;
         clean <= SW_RESET_VAL;
      end else begin
         sync1 <= raw;
         sync2 <= sync1;
         cnt   <= next_cnt;
         clean <= next_clean;
      end
   end
endmodule

// *** hdl/power_state_wake_control.sv ***
// power-state controller: switch press timing, wake sources, software soft-off
//
// How it works
// - time each switch press; short or long against four seconds picks next state
// - short press: soft-off to working, working to sleep, sleep to working
// - long press in working or sleep forces soft-off regardless of software
// - LAN, PME, switch, RTC, WAKE wake S3/S4/S5; PS/2, serial, USB only S3
// - S5 wake by LAN/PME off after reset; power-on setting enables LAN wake
// - software soft-off command moves the system to soft-off without a press
// - PME wakes S3, S4 or S5 only while wake-on-PME is enabled
`timescale 1ns/1ns
module power_state_wake_control
   import pwr_state_pkg::*;
#(
   parameter int unsigned LONG_CYC   = LONG_PRESS_CYC,
   parameter int unsigned DEBNC_CYC  = DEBOUNCE_CYC
) (
   input  wire logic       REF_CLK,
   input  wire logic       ARST_N,
   input  wire logic       PWR_SW_N,
   input  wire logic       WAKE_LAN,
   input  wire logic       PME_N,
   input  wire logic       PCIE_WAKE_N,
   input  wire logic       RTC_ALARM,
   input  wire logic       USB_WAKE,
   input  wire logic       KBD_WAKE,
   input  wire logic       SERIAL_WAKE,
   input  wire logic       OS_SOFT_OFF,
   input  wire logic       OS_SLEEP_S4,
   input  wire logic       CFG_S5_LAN_ON,
   input  wire logic       CFG_PME_WAKE_EN,
   input  wire logic       AC_PRESENT,
   output logic            PWR_ON,
   output logic            IN_WORK,
   output logic            IN_SLEEP,
   output logic            IN_SOFT_OFF,
   output logic            IN_MECH_OFF,
   output logic [1:0]      SLEEP_KIND,
   output logic            WAKE_EVENT
);
   logic                sw_clean;
   logic                sw_prev;
   logic [PRESS_W-1:0]  press_cnt;
   logic                long_done;
   pstate_e             state;
   logic [1:0]          sleep_kind;
   logic                wake_ev;
   logic                next_sw_prev;
   logic [PRESS_W-1:0]  next_press_cnt;
   logic                next_long_done;
   pstate_e             next_state;
   logic [1:0]          next_sleep_kind;
   logic                next_wake_ev;
   logic                short_rel;
   logic                long_hit;
   logic                wake_any;
   logic                wake_deep;
   logic                wake_s3only;
   logic                pme_ok;

   switch_debounce #(.STABLE_CYC(DEBNC_CYC)) u_deb (
      .clk    (REF_CLK),
      .arst_n (ARST_N),
      .raw    (~PWR_SW_N),
      .clean  (sw_clean)
   );

   // press timer: short event on release before threshold, long at threshold
   always_comb begin
      next_sw_prev   = sw_clean;
      next_press_cnt = press_cnt;
      next_long_done = long_done;
      short_rel      = 1'b0;
      long_hit       = 1'b0;
      if (sw_clean) begin
         if (!sw_prev) begin
            next_press_cnt = '0;
            next_long_done = 1'b0;
         end else if (!long_done) begin
            if (press_cnt >= PRESS_W'(LONG_CYC - 1)) begin
               long_hit       = 1'b1;
               next_long_done = 1'b1;
            end else begin
               next_press_cnt = press_cnt + PRESS_W'(1);
            end
         end
      end else if (sw_prev && !long_done) begin
         short_rel = 1'b1;
      end
   end

   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         sw_prev   <= 1'b0;
         press_cnt <= '0;
         long_done <= 1'b0;
      end else begin
         sw_prev   <= next_sw_prev;
         press_cnt <= next_press_cnt;
         long_done <= next_long_done;
      end
   end

   // wake qualification; the switch itself wakes through the short press
   assign pme_ok      = ~PME_N & CFG_PME_WAKE_EN;
   assign wake_any    = ~PCIE_WAKE_N | RTC_ALARM;
   assign wake_deep   = WAKE_LAN | pme_ok;
   assign wake_s3only = USB_WAKE | KBD_WAKE | SERIAL_WAKE;

   always_comb begin
      next_state      = state;
      next_sleep_kind = sleep_kind;
      next_wake_ev    = 1'b0;
      case (state)
         ST_MECH: begin
            if (AC_PRESENT) begin
               next_state = ST_OFF;
            end
         end
         ST_OFF: begin
            // a held software off outranks the switch; LAN and PME share the S5 setting
            if (OS_SOFT_OFF) begin
               next_state = ST_OFF;
            end else if (short_rel) begin
               next_state = ST_WORK;
            end else if (wake_any || ((WAKE_LAN || pme_ok) && CFG_S5_LAN_ON)) begin
               next_state   = ST_WORK;
               next_wake_ev = 1'b1;
            end
         end
         ST_WORK: begin
            if (long_hit || OS_SOFT_OFF) begin
               next_state = ST_OFF;
            end else if (short_rel) begin
               next_state      = ST_SLEEP;
               next_sleep_kind = OS_SLEEP_S4 ? SLP_S4 : SLP_S3;
            end
         end
         ST_SLEEP: begin
            if (long_hit || OS_SOFT_OFF) begin
               next_state = ST_OFF;
            end else if (short_rel) begin
               next_state = ST_WORK;
            end else if (wake_any || wake_deep ||
                         (wake_s3only && sleep_kind == SLP_S3)) begin
               next_state   = ST_WORK;
               next_wake_ev = 1'b1;
            end
         end
         default: next_state = ST_OFF;
      endcase
      if (!AC_PRESENT) begin
         next_state   = ST_MECH;
         next_wake_ev = 1'b0;
      end
   end

   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state       <= ST_OFF;
         sleep_kind  <= SLEEP_RESET_VAL;
         wake_ev     <= 1'b0;
         PWR_ON      <= 1'b0;
         IN_WORK     <= 1'b0;
         IN_SLEEP    <= 1'b0;
         IN_SOFT_OFF <= 1'b1;
         IN_MECH_OFF <= 1'b0;
         SLEEP_KIND  <= SLEEP_RESET_VAL;
         WAKE_EVENT  <= 1'b0;
      end else begin
         state       <= next_state;
         sleep_kind  <= next_sleep_kind;
         wake_ev     <= next_wake_ev;
         PWR_ON      <= (next_state == ST_WORK);
         IN_WORK     <= (next_state == ST_WORK);
         IN_SLEEP    <= (next_state == ST_SLEEP);
         IN_SOFT_OFF <= (next_state == ST_OFF);
         IN_MECH_OFF <= (next_state == ST_MECH);
         SLEEP_KIND  <= next_sleep_kind;
         WAKE_EVENT  <= next_wake_ev;
      end
   end

   property p_long_off;
      @(posedge REF_CLK) disable iff (!ARST_N)
      (long_hit && AC_PRESENT && (state == ST_WORK || state == ST_SLEEP))
         |=> IN_SOFT_OFF;
   endproperty
   AST_LONG_OFF: assert property (p_long_off)
      else $error("long press did not reach soft-off");

   AST_SHORT_ON: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      (short_rel && AC_PRESENT && state == ST_OFF) |=> IN_WORK)
      else $error("short press from off did not power on");

   AST_SHORT_SLEEP: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      (short_rel && !OS_SOFT_OFF && AC_PRESENT && state == ST_WORK) |=> IN_SLEEP)
      else $error("short press from working did not sleep");

   AST_OS_OFF: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      (OS_SOFT_OFF && AC_PRESENT && state != ST_MECH) |=> IN_SOFT_OFF)
      else $error("software soft-off ignored");

   AST_PME_GATE: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      (state == ST_SLEEP && !CFG_PME_WAKE_EN && WAKE_LAN == 1'b0 && !wake_any &&
       !wake_s3only && !short_rel) |=> !WAKE_EVENT)
      else $error("pme woke while disabled");

   AST_S5_LAN: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      (state == ST_OFF && AC_PRESENT && WAKE_LAN && CFG_S5_LAN_ON) |=> IN_WORK)
      else $error("lan wake from S5 missed");

   AST_S5_GATE: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      (state == ST_OFF && !CFG_S5_LAN_ON && !wake_any && !short_rel) |=> !WAKE_EVENT)
      else $error("S5 woke while LAN and PME wake were off");

   AST_S4_NO_USB: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      (state == ST_SLEEP && sleep_kind == SLP_S4 && !wake_any && !wake_deep &&
       !short_rel && !long_hit && !OS_SOFT_OFF && AC_PRESENT) |=> IN_SLEEP)
      else $error("S3-only source woke S4");

   sequence s_press_start;
      sw_clean && !sw_prev;
   endsequence
   AST_TIMER_RESTART: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      s_press_start |=> (press_cnt == '0) && !long_done)
      else $error("press timer not restarted");

   AST_DEB_STABLE: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      $rose(sw_clean) |=> sw_clean [*2])
      else $error("debounced switch chattered");
endmodule

// *** verification/wake_src_model.sv ***
// model of the power switch and the wake-event sources
`timescale 1ns/1ns
module wake_src_model (
   input  wire logic clk,
   output logic      pwr_sw_n,
   output logic      wake_lan,
   output logic      pme_n,
   output logic      pcie_wake_n,
   output logic      rtc_alarm,
   output logic      usb_wake,
   output logic      kbd_wake,
   output logic      serial_wake
);
   initial begin
      {pwr_sw_n, wake_lan, pme_n, pcie_wake_n, rtc_alarm, usb_wake, kbd_wake, serial_wake} = 8'hb0;
   end
   // contact bounce shorter than the debounce span, then a steady hold
   task automatic press(input int hold, input int bounces);
      for (int i = 0; i < 2 * bounces; i++) begin
         @(negedge clk);
         pwr_sw_n = ~pwr_sw_n;
      end
      @(negedge clk);
      pwr_sw_n = 1'b0;
      repeat (hold) @(negedge clk);
      pwr_sw_n = 1'b1;
   endtask
   task automatic fire(input int src, input logic on);
      @(negedge clk);
      case (src)
         0: wake_lan = on;
         1: pme_n = ~on;
         2: pcie_wake_n = ~on;
         3: rtc_alarm = on;
         4: usb_wake = on;
         5: kbd_wake = on;
         default: serial_wake = on;
      endcase
   endtask
endmodule

// *** verification/power_state_wake_control_tb_top.sv ***
// self-checking bench for the power-state controller
`timescale 1ns/1ns
module power_state_wake_control_tb_top;
   import pwr_state_pkg::*;
   logic       ref_clk, arst_n, pwr_sw_n, wake_lan, pme_n, pcie_wake_n, rtc_alarm;
   logic       usb_wake, kbd_wake, serial_wake, os_soft_off, os_sleep_s4;
   logic       cfg_s5_lan_on, cfg_pme_wake_en, ac_present, wake_event;
   logic       pwr_on, in_work, in_sleep, in_soft_off, in_mech_off;
   logic [1:0] sleep_kind;
   int         n_errors = 0;
   int         total_checks = 0;

   power_state_wake_control #(.LONG_CYC(50), .DEBNC_CYC(4)) i_power_state_wake_control (
      .REF_CLK(ref_clk), .ARST_N(arst_n), .PWR_SW_N(pwr_sw_n), .WAKE_LAN(wake_lan),
      .PME_N(pme_n), .PCIE_WAKE_N(pcie_wake_n), .RTC_ALARM(rtc_alarm), .USB_WAKE(usb_wake),
      .KBD_WAKE(kbd_wake), .SERIAL_WAKE(serial_wake), .OS_SOFT_OFF(os_soft_off),
      .OS_SLEEP_S4(os_sleep_s4), .CFG_S5_LAN_ON(cfg_s5_lan_on),
      .CFG_PME_WAKE_EN(cfg_pme_wake_en), .AC_PRESENT(ac_present), .PWR_ON(pwr_on),
      .IN_WORK(in_work), .IN_SLEEP(in_sleep), .IN_SOFT_OFF(in_soft_off),
      .IN_MECH_OFF(in_mech_off), .SLEEP_KIND(sleep_kind), .WAKE_EVENT(wake_event));

   wake_src_model i_wake_src_model (
      .clk(ref_clk), .pwr_sw_n(pwr_sw_n), .wake_lan(wake_lan), .pme_n(pme_n),
      .pcie_wake_n(pcie_wake_n), .rtc_alarm(rtc_alarm), .usb_wake(usb_wake),
      .kbd_wake(kbd_wake), .serial_wake(serial_wake));

   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   task automatic tally_and_finish();
      if (n_errors == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_st(input pstate_e exp);
      chk("state", exp, {in_mech_off, in_sleep, in_work, in_soft_off});
      chk("power", {3'h0, exp == ST_WORK}, {3'h0, pwr_on});
   endtask

   // short-press hold and bounce counts vary, every hold staying well under the long-press threshold
   task automatic sp();
      i_wake_src_model.press(10 + $urandom_range(15), $urandom_range(3));
      repeat (15) @(negedge ref_clk);
   endtask

   task automatic lp();
      i_wake_src_model.press(70 + $urandom_range(20), $urandom_range(2));
      repeat (15) @(negedge ref_clk);
   endtask

   task automatic os_off();
      os_soft_off = 1'b1;
      @(negedge ref_clk);
      os_soft_off = 1'b0;
      repeat (3) @(negedge ref_clk);
      chk_st(ST_OFF);
   endtask

   task automatic go_to(input int st);
      if (in_work !== 1'b1) sp();
      chk_st(ST_WORK);
      if (st == 5) begin
         os_off();
      end else begin
         os_sleep_s4 = (st == 4);
         sp();
         chk_st(ST_SLEEP);
         chk("kind", {2'h0, (st == 4) ? SLP_S4 : SLP_S3}, {2'h0, sleep_kind});
      end
   endtask

   function automatic logic exp_wake(input int src, input int st, input logic lan5,
                                     input logic pme_en);
      case (src)
         0: return (st != 5) || lan5;
         1: return pme_en && ((st != 5) || lan5);
         2, 3: return 1'b1;
         default: return st == 3;
      endcase
   endfunction

   task automatic trial(input int src, input int st);
      logic lan5, pme_en, ev, want;
      lan5 = $urandom_range(1);
      pme_en = $urandom_range(1);
      go_to(st);
      cfg_s5_lan_on = lan5;
      cfg_pme_wake_en = pme_en;
      want = exp_wake(src, st, lan5, pme_en);
      ev = 1'b0;
      i_wake_src_model.fire(src, 1'b1);
      repeat (6) begin
         @(posedge ref_clk);
         #1 ev = ev | (wake_event === 1'b1);
      end
      i_wake_src_model.fire(src, 1'b0);
      repeat (3) @(negedge ref_clk);
      chk("woke", {3'h0, want}, {3'h0, in_work});
      chk("wake pulse", {3'h0, want}, {3'h0, ev});
   endtask

   // span well beyond the longest expected run of presses and wake trials
   initial begin
      #(40 * 60000);
      n_errors++;
      tally_and_finish();
   end

   initial begin
      {arst_n, os_soft_off, os_sleep_s4, cfg_s5_lan_on, cfg_pme_wake_en, ac_present} = 6'h01;
      void'($urandom(32'he67c6e9b));
      repeat (10) @(negedge ref_clk);
      arst_n = 1'b1;
      chk_st(ST_OFF);
      chk("kind", {2'h0, SLEEP_RESET_VAL}, {2'h0, sleep_kind});
      sp();
      chk_st(ST_WORK);
      lp();
      chk_st(ST_OFF);
      for (int st = 3; st <= 4; st++) begin
         go_to(st);
         lp();
         chk_st(ST_OFF);
      end
      go_to(3);
      os_off();
      for (int rep = 0; rep < 2; rep++) begin
         for (int src = 0; src < 7; src++) begin
            for (int st = 3; st <= 5; st++) trial(src, st);
         end
      end
      ac_present = 1'b0;
      repeat (2) @(negedge ref_clk);
      chk_st(ST_MECH);
      ac_present = 1'b1;
      repeat (3) @(negedge ref_clk);
      chk_st(ST_OFF);
      tally_and_finish();
   end
endmodule
